// ### wdtm_pkg.sv
// constants, field positions, reset values and carrier types of the watchdog time-out monitor
// assumes one clock domain (mclk_i, 125 MHz) and a plain byte-wide register port
package wdtm_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int unsigned WDTM_CNT_W = 27;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_WDCTL = 8'h00;
    localparam logic [7:0] OFS_CLKCTL = 8'h01;
    localparam logic [7:0] OFS_TIMED_ACCESS = 8'h02;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h03;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h05;
    localparam logic [7:0] OFS_WD_INT_CTL = 8'h06;
    localparam logic [7:0] OFS_WD_STATE = 8'h07;
    localparam logic [7:0] OFS_CNT_B0 = 8'h08;
    localparam logic [7:0] OFS_CNT_B1 = 8'h09;
    localparam logic [7:0] OFS_CNT_B2 = 8'h0a;
    localparam logic [7:0] OFS_CNT_B3 = 8'h0b;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned WDCTL_POWER_ON_BIT = 6;
    localparam int unsigned WDCTL_TIMEOUT_BIT = 3;
    localparam int unsigned WDCTL_CAUSE_BIT = 2;
    localparam int unsigned WDCTL_RESET_EN_BIT = 1;
    localparam int unsigned WDCTL_RESTART_BIT = 0;
    localparam int unsigned CLKCTL_INTERVAL_LSB = 6;
    localparam int unsigned IRQ_TIMEOUT_BIT = 0;
    localparam int unsigned IRQ_WD_RESET_BIT = 1;
    localparam int unsigned INTCTL_WD_EN_BIT = 0;
    localparam int unsigned INTCTL_GLOBAL_EN_BIT = 7;
    localparam int unsigned STATE_PENDING_BIT = 0;
    localparam int unsigned STATE_SYS_RST_BIT = 1;
    localparam int unsigned STATE_UNLOCKED_BIT = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CLKCTL_RESET = 8'h00;
    localparam logic [1:0] IRQ_REG_RESET = 2'h0;
    localparam logic [7:0] INTCTL_RESET = 8'h00;

    // ****************************************
    // timing counts and timed-access keys
    // ****************************************
    localparam logic [WDTM_CNT_W-1:0] RESET_DELAY_CLKS = 27'h0000200;
    localparam int unsigned MACHINE_CYCLE_CLKS = 4;
    localparam logic [3:0] RESET_PULSE_CLKS = 4'(2 * MACHINE_CYCLE_CLKS);
    localparam logic [2:0] TA_WINDOW_CLKS = 3'h4;
    localparam logic [7:0] TA_KEY_FIRST = 8'haa;
    localparam logic [7:0] TA_KEY_SECOND = 8'h55;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdtm_bus_req_type;

    typedef enum logic [1:0] {
        TA_LOCKED,
        TA_ARMED,
        TA_OPEN
    } wdtm_ta_state_type;

    typedef struct packed {
        wdtm_ta_state_type state;
        logic [2:0] win;
    } wdtm_ta_type;

    typedef struct packed {
        logic [WDTM_CNT_W-1:0] cnt;
        logic power_on;
        logic timeout;
        logic cause;
        logic reset_en;
        logic pending;
        logic [7:0] clkctl;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic [7:0] intctl;
        logic [3:0] rst_cnt;
        logic [23:0] cnt_snap;
        logic ext_meta;
        logic ext_sync;
        logic [7:0] rdata;
    } wdtm_state_type;

    localparam wdtm_state_type WDTM_STATE_RESET = '{
        cnt: '0,
        power_on: 1'b1,
        timeout: 1'b0,
        cause: 1'b0,
        reset_en: 1'b0,
        pending: 1'b0,
        clkctl: CLKCTL_RESET,
        irq_status: IRQ_REG_RESET,
        irq_enable: IRQ_REG_RESET,
        intctl: INTCTL_RESET,
        rst_cnt: 4'h0,
        cnt_snap: 24'h000000,
        ext_meta: 1'b0,
        ext_sync: 1'b0,
        rdata: 8'h00
    };

endpackage

// ### wdtm_timed_access.sv
// timed-access unlock sequencer for the protected watchdog control bits
// assumes key writes and the consuming write come from logic on mclk_i
module wdtm_timed_access
    import wdtm_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic key_we_i,
    input wire logic [7:0] key_i,
    input wire logic consume_i,
    output logic open_o
);

    wdtm_ta_type s_q;
    wdtm_ta_type s_d;

    // ****************************************
    // sequencer
    // ****************************************
    // the second key must follow within the window, and one unlock buys one write
    always_comb begin
        s_d = s_q;
        if (s_q.win != 3'h0) begin
            s_d.win = s_q.win - 3'h1;
        end
        case (s_q.state)
            TA_LOCKED: begin
                if (key_we_i && key_i == TA_KEY_FIRST) begin
                    s_d.state = TA_ARMED;
                    s_d.win = TA_WINDOW_CLKS - 3'h1;
                end
            end
            TA_ARMED: begin
                if (key_we_i) begin
                    if (key_i == TA_KEY_SECOND) begin
                        s_d.state = TA_OPEN;
                        s_d.win = TA_WINDOW_CLKS - 3'h1;
                    end else begin
                        s_d.state = TA_LOCKED;
                    end
                end else if (s_q.win == 3'h0) begin
                    s_d.state = TA_LOCKED;
                end
            end
            TA_OPEN: begin
                if (consume_i || key_we_i || s_q.win == 3'h0) begin
                    s_d.state = TA_LOCKED;
                end
            end
            default: begin
                s_d.state = TA_LOCKED;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_q <= '{state: TA_LOCKED, win: 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign open_o = (s_q.state == TA_OPEN);

endmodule

// ### wdtm_watchdog.sv
// watchdog time-out monitor: divider counter, time-out flag, delayed system reset,
// register port, interrupt status/enable and timed-access protection
// assumes rst_n_i is the power-on/power-fail reset and ext_rst_i an asynchronous pin
// Behaviour
// - free-running counter divides clock; selected time-out sets the time-out flag
// - watchdog interrupt needs time-out flag, watchdog enable and global enable
// - interrupt path and reset path are enabled independently
// - restart bit zeroes the counter and always reads back as zero
// - after restart count clocks; interval from clock control bits 7:6
// - intervals 2^17, 2^20, 2^23, 2^26; reset 512 clocks later
// - with reset enabled, system reset follows flag by exactly 512 clocks
// - watchdog reset lasts two machine cycles and sets the cause flag bit 2
// - time-out flag bit 3 sets regardless of enables; software or power-on reset clears it
// - power-on or power-fail reset disables the watchdog reset function
// - external or watchdog reset only restarts the counter, enables kept
// - power-on flag bit 6 set at power-up; software may write it
// - cause flag untouched while reset disabled; software or power-fail clears it
// - watchdog reset works only while reset enable bit 1 is one
// - power-on, reset enable, time-out and restart writes need timed access
// - interval field resets to shortest setting, 2^17 clocks
//
// Implementation choices: the register addresses and the strobed register port.
module wdtm_watchdog
    import wdtm_pkg::*;
#(
    parameter logic [WDTM_CNT_W-1:0] TIMEOUT_CLKS_0 = 27'h0020000,
    parameter logic [WDTM_CNT_W-1:0] TIMEOUT_CLKS_1 = 27'h0100000,
    parameter logic [WDTM_CNT_W-1:0] TIMEOUT_CLKS_2 = 27'h0800000,
    parameter logic [WDTM_CNT_W-1:0] TIMEOUT_CLKS_3 = 27'h4000000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire wdtm_bus_req_type bus_i,
    input wire logic ext_rst_i,
    output logic [7:0] rdata_o,
    output logic sys_rst_o,
    output logic wd_irq_o,
    output logic irq_o
);

    wdtm_state_type s_q;
    wdtm_state_type s_d;
    logic ta_open;
    logic wd_we;
    logic prot_we;
    logic ta_key_we;
    logic restart;
    logic timeout_evt;
    logic reset_evt;
    logic [WDTM_CNT_W-1:0] int_to;
    logic [WDTM_CNT_W-1:0] rst_to;

    // ****************************************
    // timed access
    // ****************************************
    assign ta_key_we = bus_i.wr && bus_i.addr == OFS_TIMED_ACCESS;
    assign wd_we = bus_i.wr && bus_i.addr == OFS_WDCTL;
    assign prot_we = wd_we && ta_open;

    wdtm_timed_access u_timed_access (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .key_we_i(ta_key_we),
        .key_i(bus_i.wdata),
        .consume_i(wd_we),
        .open_o(ta_open)
    );

    // ****************************************
    // interval selection
    // ****************************************
    always_comb begin
        case (s_q.clkctl[CLKCTL_INTERVAL_LSB +: 2])
            2'h0: int_to = TIMEOUT_CLKS_0;
            2'h1: int_to = TIMEOUT_CLKS_1;
            2'h2: int_to = TIMEOUT_CLKS_2;
            2'h3: int_to = TIMEOUT_CLKS_3;
            default: int_to = TIMEOUT_CLKS_0;
        endcase
        rst_to = int_to + RESET_DELAY_CLKS;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;

        // pin crossing; only the second stage is read
        s_d.ext_meta = ext_rst_i;
        s_d.ext_sync = s_q.ext_meta;

        // events from the divider
        timeout_evt = (s_q.cnt == int_to - 27'h1);
        reset_evt = s_q.reset_en && s_q.pending && (s_q.cnt == rst_to - 27'h1);

        // counter and restart sources
        restart = (prot_we && bus_i.wdata[WDCTL_RESTART_BIT])
            || s_q.ext_sync
            || (s_q.rst_cnt != 4'h0)
            || reset_evt;
        if (restart) begin
            s_d.cnt = '0;
            s_d.pending = 1'b0;
        end else begin
            s_d.cnt = s_q.cnt + 27'h1;
            if (timeout_evt) begin
                s_d.pending = 1'b1;
            end
        end

        // protected control bits; the restart bit itself is never stored
        if (prot_we) begin
            s_d.power_on = bus_i.wdata[WDCTL_POWER_ON_BIT];
            s_d.timeout = bus_i.wdata[WDCTL_TIMEOUT_BIT];
            s_d.reset_en = bus_i.wdata[WDCTL_RESET_EN_BIT];
        end
        // cause flag is cleared by an ordinary write of zero
        if (wd_we && !bus_i.wdata[WDCTL_CAUSE_BIT]) begin
            s_d.cause = 1'b0;
        end
        // hardware sets after software clears, so a same-cycle event is kept
        if (timeout_evt && !restart) begin
            s_d.timeout = 1'b1;
        end
        if (reset_evt) begin
            s_d.cause = 1'b1;
        end

        // system reset pulse of two machine cycles
        if (reset_evt) begin
            s_d.rst_cnt = RESET_PULSE_CLKS;
        end else if (s_q.rst_cnt != 4'h0) begin
            s_d.rst_cnt = s_q.rst_cnt - 4'h1;
        end

        // unprotected registers
        if (bus_i.wr && bus_i.addr == OFS_CLKCTL) begin
            s_d.clkctl = bus_i.wdata;
        end
        if (bus_i.wr && bus_i.addr == OFS_IRQ_ENABLE) begin
            s_d.irq_enable = bus_i.wdata[1:0];
        end
        if (bus_i.wr && bus_i.addr == OFS_WD_INT_CTL) begin
            s_d.intctl = bus_i.wdata;
        end

        // sticky interrupt status: clear first, then set so the event wins
        if (bus_i.wr && bus_i.addr == OFS_IRQ_CLEAR) begin
            s_d.irq_status = s_q.irq_status & ~bus_i.wdata[1:0];
        end
        if (timeout_evt && !restart) begin
            s_d.irq_status[IRQ_TIMEOUT_BIT] = 1'b1;
        end
        if (reset_evt) begin
            s_d.irq_status[IRQ_WD_RESET_BIT] = 1'b1;
        end

        // counter snapshot: reading byte 0 freezes the upper bytes for a coherent read
        if (bus_i.rd && bus_i.addr == OFS_CNT_B0) begin
            s_d.cnt_snap = {5'h00, s_q.cnt[WDTM_CNT_W-1:8]};
        end

        // read data stands for exactly one cycle after the strobe
        s_d.rdata = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                OFS_WDCTL: begin
                    s_d.rdata[WDCTL_POWER_ON_BIT] = s_q.power_on;
                    s_d.rdata[WDCTL_TIMEOUT_BIT] = s_q.timeout;
                    s_d.rdata[WDCTL_CAUSE_BIT] = s_q.cause;
                    s_d.rdata[WDCTL_RESET_EN_BIT] = s_q.reset_en;
                end
                OFS_CLKCTL: s_d.rdata = s_q.clkctl;
                OFS_IRQ_STATUS: s_d.rdata = {6'h00, s_q.irq_status};
                OFS_IRQ_ENABLE: s_d.rdata = {6'h00, s_q.irq_enable};
                OFS_WD_INT_CTL: s_d.rdata = s_q.intctl;
                OFS_WD_STATE: begin
                    s_d.rdata[STATE_PENDING_BIT] = s_q.pending;
                    s_d.rdata[STATE_SYS_RST_BIT] = (s_q.rst_cnt != 4'h0);
                    s_d.rdata[STATE_UNLOCKED_BIT] = ta_open;
                end
                OFS_CNT_B0: s_d.rdata = s_q.cnt[7:0];
                OFS_CNT_B1: s_d.rdata = s_q.cnt_snap[7:0];
                OFS_CNT_B2: s_d.rdata = s_q.cnt_snap[15:8];
                OFS_CNT_B3: s_d.rdata = s_q.cnt_snap[23:16];
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // power-on reset clears the reset enable and cause, sets the power-on flag
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_q <= WDTM_STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_o = s_q.rdata;
    assign sys_rst_o = (s_q.rst_cnt != 4'h0);
    assign wd_irq_o = s_q.timeout && s_q.intctl[INTCTL_WD_EN_BIT]
        && s_q.intctl[INTCTL_GLOBAL_EN_BIT];
    assign irq_o = |(s_q.irq_status & s_q.irq_enable);

endmodule

// ### wdtm_watchdog_props.sv
// port-level assertions for the watchdog time-out monitor
// assumes one clock mclk_i and a synchronous active-low rst_n_i
module wdtm_watchdog_props
    import wdtm_pkg::*;
#(
    parameter logic [WDTM_CNT_W-1:0] TIMEOUT_CLKS_0 = 27'h0020000
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire wdtm_bus_req_type bus_i,
    input wire logic ext_rst_i,
    input wire logic [7:0] rdata_o,
    input wire logic sys_rst_o,
    input wire logic wd_irq_o,
    input wire logic irq_o
);
    // ****************************************
    // helpers
    // ****************************************
    // gap counter saturates so a long quiet run cannot wrap into a false pass
    logic [27:0] low_cnt_q;
    logic key_seen_q;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || sys_rst_o) begin
            low_cnt_q <= 28'h0000000;
        end else if (low_cnt_q != 28'hfffffff) begin
            low_cnt_q <= low_cnt_q + 28'h0000001;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            key_seen_q <= 1'b0;
        end else if (bus_i.wr && bus_i.addr == OFS_TIMED_ACCESS && bus_i.wdata == TA_KEY_SECOND) begin
            key_seen_q <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ****************************************
    // assertions
    // ****************************************
    AST_RD_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_RESTART_RD: assert property ($past(bus_i.rd) && $past(bus_i.addr) == OFS_WDCTL |-> !rdata_o[0])
        else $error("restart bit read back as one");
    AST_PULSE: assert property ($rose(sys_rst_o) |-> sys_rst_o [*8] ##1 !sys_rst_o)
        else $error("system reset pulse not eight cycles");
    // lower bound only: restarts and interval changes may legally lengthen the gap
    AST_GAP: assert property ($rose(sys_rst_o) |-> low_cnt_q >= {1'b0, TIMEOUT_CLKS_0} + 28'h00001f0)
        else $error("system reset too soon after counter start");
    AST_ARMED: assert property ($rose(sys_rst_o) |-> key_seen_q)
        else $error("system reset without any unlock since power-on");
    AST_EXT_HOLD: assert property (ext_rst_i [*5] |-> !$rose(sys_rst_o))
        else $error("system reset rose while external reset held");
    AST_WDIRQ_FALL: assert property ($fell(wd_irq_o) |-> $past(bus_i.wr))
        else $error("watchdog interrupt dropped without a write");
    AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(bus_i.wr))
        else $error("interrupt dropped without a write");
endmodule

bind wdtm_watchdog wdtm_watchdog_props #(.TIMEOUT_CLKS_0(TIMEOUT_CLKS_0)) props_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .bus_i(bus_i),
    .ext_rst_i(ext_rst_i),
    .rdata_o(rdata_o),
    .sys_rst_o(sys_rst_o),
    .wd_irq_o(wd_irq_o),
    .irq_o(irq_o)
);

// ### wdtm_watchdog_test.sv
// self-checking bench for the watchdog time-out monitor
// assumes the checker is bound in; time-outs shortened to 16, 32, 64, 128 clocks
module wdtm_watchdog_test
    import wdtm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TOS [4] = '{32'h10, 32'h20, 32'h40, 32'h80};
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ext_rst_i = 1'b0;
    wdtm_bus_req_type bus_req = '0;
    logic [7:0] rdata_o;
    logic sys_rst_o;
    logic wd_irq_o;
    logic irq_o;
    int fail_count = 0;
    int n_compared = 0;
    int rise_count = 0;
    int n;
    int n0;
    logic [7:0] v;
    wdtm_watchdog #(.TIMEOUT_CLKS_0(27'h10), .TIMEOUT_CLKS_1(27'h20), .TIMEOUT_CLKS_2(27'h40),
        .TIMEOUT_CLKS_3(27'h80)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_req),
        .ext_rst_i(ext_rst_i), .rdata_o(rdata_o), .sys_rst_o(sys_rst_o), .wd_irq_o(wd_irq_o), .irq_o(irq_o));
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    always @(posedge sys_rst_o) begin
        rise_count++;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        bus_req <= '0;
        // outputs launched by this edge settle before the caller compares them
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        bus_req <= '0;
        #1;
        d = rdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // one protected write per unlock, so every caller unlocks again
    task automatic pwr(input logic [7:0] d);
        wr(OFS_TIMED_ACCESS, TA_KEY_FIRST);
        wr(OFS_TIMED_ACCESS, TA_KEY_SECOND);
        wr(OFS_WDCTL, d);
    endtask
    task automatic wait_sig(input bit want_irq, input logic lvl, output int c);
        c = 0;
        #1;
        while ((want_irq ? irq_o : sys_rst_o) !== lvl && c < 2000) begin
            @(posedge mclk_i);
            #1;
            c++;
        end
    endtask
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (30000) @(posedge mclk_i);
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdc(OFS_WDCTL, 8'h40);
        rdc(OFS_CLKCTL, CLKCTL_RESET);
        rdc(OFS_IRQ_STATUS, 8'h00);
        rdc(8'h3c, 8'h00);
        $display("test reset values done");
        wr(OFS_WDCTL, 8'h03);
        rdc(OFS_WDCTL, 8'h40);
        wr(OFS_TIMED_ACCESS, TA_KEY_FIRST);
        wr(OFS_TIMED_ACCESS, TA_KEY_SECOND);
        rdc(OFS_WD_STATE, 8'h05);
        repeat (6) @(posedge mclk_i);
        wr(OFS_WDCTL, 8'h02);
        // the shortened first interval has run out by now, so the time-out flag reads set
        rdc(OFS_WDCTL, 8'h48);
        $display("test protection done");
        wr(OFS_IRQ_ENABLE, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_IRQ_CLEAR, 8'h03);
            wr(OFS_CLKCTL, 8'(i << 6));
            pwr(8'h41);
            wait_sig(1'b1, 1'b1, n);
            if (i == 0) begin
                n0 = n;
            end
            chk(8'(n - TOS[i]), 8'(n0 - TOS[0]));
            rdc(OFS_WDCTL, 8'h48);
            chk({7'h0, wd_irq_o}, 8'h00);
        end
        chk({7'h0, n0 >= 16 && n0 <= 18}, 8'h01);
        wr(OFS_IRQ_ENABLE, 8'h00);
        chk({7'h0, irq_o}, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h01);
        chk({7'h0, irq_o}, 8'h01);
        wr(OFS_WD_INT_CTL, 8'h01);
        chk({7'h0, wd_irq_o}, 8'h00);
        wr(OFS_WD_INT_CTL, 8'h81);
        chk({7'h0, wd_irq_o}, 8'h01);
        wr(OFS_IRQ_CLEAR, 8'h01);
        chk({7'h0, irq_o}, 8'h00);
        chk({7'h0, wd_irq_o}, 8'h01);
        wr(OFS_CLKCTL, 8'h00);
        repeat (6) pwr(8'h41);
        chk({7'h0, irq_o}, 8'h00);
        chk({7'h0, wd_irq_o}, 8'h00);
        $display("test intervals and interrupts done");
        wr(OFS_IRQ_ENABLE, 8'h03);
        pwr(8'h43);
        wait_sig(1'b1, 1'b1, n);
        wait_sig(1'b0, 1'b1, n);
        chk(8'(n - 511), 8'h01);
        wait_sig(1'b0, 1'b0, n);
        chk(8'(n), 8'h08);
        rdc(OFS_WDCTL, 8'h4e);
        rdc(OFS_IRQ_STATUS, 8'h03);
        wr(OFS_WDCTL, 8'h00);
        rdc(OFS_WDCTL, 8'h4a);
        @(posedge mclk_i);
        ext_rst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        ext_rst_i <= 1'b0;
        rd(OFS_CNT_B0, v);
        chk({7'h0, v < 8'h08}, 8'h01);
        rdc(OFS_CNT_B1, 8'h00);
        rd(OFS_WDCTL, v);
        chk(v & 8'h02, 8'h02);
        n = rise_count;
        pwr(8'h41);
        repeat (700) @(posedge mclk_i);
        chk(8'(rise_count - n), 8'h00);
        rdc(OFS_WDCTL, 8'h48);
        $display("test reset path done");
        pwr(8'h43);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdc(OFS_WDCTL, 8'h40);
        $display("test power reset done");
        stop_test();
    end
endmodule
